// ===== core/error_counter.sv
// Eight-bit saturating or wrapping error counter with software load
`timescale 1ns/1ps
module error_counter
    import error_monitor_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic increment,
    input wire logic wrap_enable,
    input wire logic load,
    input wire logic [7:0] load_value,
    output logic [7:0] count
);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= count_reset;
        end else if (load) begin
            count <= load_value;
        end else if (increment) begin
            if (count != count_max || wrap_enable) begin
                count <= count + 8'h01;
            end
        end
    end

    a_saturate_hold: assert property (@(posedge clk) disable iff (!resetn)
        (increment && !load && !wrap_enable && count == count_max) |=> count == count_max)
        else $error("counter left saturation");

    a_wrap_zero: assert property (@(posedge clk) disable iff (!resetn)
        (increment && !load && wrap_enable && count == count_max) |=> count == 8'h00)
        else $error("counter did not wrap");

    a_load_wins: assert property (@(posedge clk) disable iff (!resetn)
        load |=> count == $past(load_value))
        else $error("written value lost");

endmodule : error_counter

// ===== core/error_monitor.sv
// Far-end and near-end block error monitoring with crc corruption
`timescale 1ns/1ps
module error_monitor
    import error_monitor_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [addr_width-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Receive side superframe events, same clock
    input wire logic rx_superframe_end,
    input wire logic rx_far_error_bit,
    input wire logic rx_crc_match,
    input wire logic superframe_period_tick,
    // Link state pins
    input wire logic superframe_lock,
    input wire logic link_established,
    input wire logic line_end_mode,
    // Transmit side timing, same clock
    input wire logic tx_frame_end,
    input wire logic [3:0] tx_frame_number,
    input wire logic tx_superframe_end,
    input wire logic tx_crc_bit,
    // Transmit outputs
    output logic tx_far_error_bit,
    output logic tx_far_error_valid,
    output logic tx_crc_out
);

    // ==========================================================
    // Pin synchronisers
    logic lock_meta;
    logic lock_sync;
    logic link_meta;
    logic link_sync;
    logic mode_meta;
    logic mode_sync;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
            link_meta <= 1'b0;
            link_sync <= 1'b0;
            mode_meta <= 1'b0;
            mode_sync <= 1'b0;
        end else begin
            lock_meta <= superframe_lock;
            lock_sync <= lock_meta;
            link_meta <= link_established;
            link_sync <= link_meta;
            mode_meta <= line_end_mode;
            mode_sync <= mode_meta;
        end
    end

    logic in_sync;
    assign in_sync = lock_sync && link_sync;

    // ==========================================================
    // Bus slave
    logic [ctl_width-1:0] control;
    logic [7:0] far_error_count;
    logic [7:0] near_error_count;
    logic received_far_error_bit;
    logic computed_near_error_bit;
    logic crc_invert_active;
    logic access_done;

    logic far_error_source_select;
    logic far_error_input_bit;
    logic error_counter_wrap_enable;
    logic crc_invert_request;
    logic crc_invert_single_superframe;
    assign far_error_source_select = control[ctl_far_source];
    assign far_error_input_bit = control[ctl_far_input];
    assign error_counter_wrap_enable = control[ctl_wrap];
    assign crc_invert_request = control[ctl_crc_invert];
    assign crc_invert_single_superframe = control[ctl_single];

    logic word_hit;
    logic [2:0] word_index;
    logic write_take;
    assign word_index = address[4:2];
    assign word_hit = address[1:0] == 2'h0;
    assign waitrequest = (read || write) && !access_done;
    assign write_take = write && !waitrequest && word_hit && byteenable[0];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            access_done <= 1'b0;
        end else begin
            access_done <= (read || write) && !access_done;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readdata <= 32'h0000_0000;
        end else if (read && !access_done) begin
            readdata <= 32'h0000_0000;
            if (word_hit) begin
                case (word_index)
                    reg_far_count: readdata[7:0] <= far_error_count;
                    reg_near_count: readdata[7:0] <= near_error_count;
                    reg_control: readdata[ctl_width-1:0] <= control;
                    reg_status: begin
                        readdata[st_received_far] <= received_far_error_bit;
                        readdata[st_near] <= computed_near_error_bit;
                        readdata[st_lock] <= lock_sync;
                        readdata[st_link] <= link_sync;
                        readdata[st_tx_far] <= tx_far_error_bit;
                        readdata[st_invert_active] <= crc_invert_active;
                    end
                    default: readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ==========================================================
    // Control register and crc corruption request
    logic auto_clear;
    assign auto_clear = crc_invert_single_superframe && crc_invert_request && tx_superframe_end;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            control <= control_reset;
        end else begin
            if (write_take && word_index == reg_control) begin
                control <= writedata[ctl_width-1:0];
            end
            if (auto_clear) begin
                control[ctl_crc_invert] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Received error bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            received_far_error_bit <= 1'b1;
        end else if (rx_superframe_end && in_sync) begin
            received_far_error_bit <= rx_far_error_bit;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            computed_near_error_bit <= 1'b0;
        end else if (!in_sync) begin
            computed_near_error_bit <= 1'b0;
        end else if (rx_superframe_end) begin
            computed_near_error_bit <= rx_crc_match;
        end
    end

    // ==========================================================
    // Error counters
    logic far_increment;
    logic near_increment;
    assign far_increment = rx_superframe_end && in_sync && !rx_far_error_bit;
    assign near_increment = (rx_superframe_end && in_sync && !rx_crc_match)
        || (superframe_period_tick && link_sync && !lock_sync);

    error_counter far_counter (
        .clk(clk),
        .resetn(resetn),
        .increment(far_increment),
        .wrap_enable(error_counter_wrap_enable),
        .load(write_take && word_index == reg_far_count),
        .load_value(writedata[7:0]),
        .count(far_error_count)
    );

    error_counter near_counter (
        .clk(clk),
        .resetn(resetn),
        .increment(near_increment),
        .wrap_enable(error_counter_wrap_enable),
        .load(write_take && word_index == reg_near_count),
        .load_value(writedata[7:0]),
        .count(near_error_count)
    );

    // ==========================================================
    // Outgoing far error bit
    logic next_far_bit;
    always_comb begin
        if (far_error_source_select) begin
            next_far_bit = far_error_input_bit;
        end else begin
            next_far_bit = computed_near_error_bit && far_error_input_bit;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_far_error_bit <= 1'b1;
            tx_far_error_valid <= 1'b0;
        end else begin
            tx_far_error_valid <= tx_frame_end && tx_frame_number == frame_far_tx;
            if (tx_frame_end && tx_frame_number == frame_far_tx) begin
                tx_far_error_bit <= next_far_bit;
            end
        end
    end

    // ==========================================================
    // Transmitted crc corruption
    logic frame_in_window;
    always_comb begin
        if (mode_sync) begin
            frame_in_window = tx_frame_number >= frame_first
                && tx_frame_number <= frame_last;
        end else begin
            frame_in_window = tx_frame_number >= frame_nt_inv_first
                && tx_frame_number <= frame_nt_inv_last;
        end
    end

    assign crc_invert_active = crc_invert_request && frame_in_window;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_crc_out <= 1'b0;
        end else begin
            tx_crc_out <= tx_crc_bit ^ crc_invert_active;
        end
    end

    // ==========================================================
    // Checks
    sequence s_sync_end;
        rx_superframe_end && in_sync;
    endsequence

    a_far_latch: assert property (@(posedge clk) disable iff (!resetn)
        s_sync_end |=> received_far_error_bit == $past(rx_far_error_bit))
        else $error("received far bit not latched");

    a_far_hold: assert property (@(posedge clk) disable iff (!resetn)
        !in_sync |=> $stable(received_far_error_bit))
        else $error("far bit changed out of sync");

    a_near_crc: assert property (@(posedge clk) disable iff (!resetn)
        s_sync_end |=> computed_near_error_bit == $past(rx_crc_match))
        else $error("near bit not from crc");

    a_near_forced: assert property (@(posedge clk) disable iff (!resetn)
        !in_sync |=> !computed_near_error_bit)
        else $error("near bit not forced low");

    a_far_select: assert property (@(posedge clk) disable iff (!resetn)
        (tx_frame_end && tx_frame_number == frame_far_tx && far_error_source_select)
        |=> tx_far_error_valid && tx_far_error_bit == $past(far_error_input_bit))
        else $error("selected far bit wrong");

    a_far_merge: assert property (@(posedge clk) disable iff (!resetn)
        (tx_frame_end && tx_frame_number == frame_far_tx && !far_error_source_select
        && !computed_near_error_bit) |=> !tx_far_error_bit)
        else $error("near error not sent");

    a_crc_invert: assert property (@(posedge clk) disable iff (!resetn)
        (crc_invert_request && frame_in_window) |=> tx_crc_out == !$past(tx_crc_bit))
        else $error("crc not inverted");

    a_crc_clean: assert property (@(posedge clk) disable iff (!resetn)
        !crc_invert_request |=> tx_crc_out == $past(tx_crc_bit))
        else $error("crc corrupted without request");

    a_single_clear: assert property (@(posedge clk) disable iff (!resetn)
        (auto_clear && !write_take) |=> !crc_invert_request)
        else $error("single mode did not clear");

    a_continuous: assert property (@(posedge clk) disable iff (!resetn)
        (crc_invert_request && !crc_invert_single_superframe && !write_take)
        |=> crc_invert_request)
        else $error("continuous request dropped");

    a_lock_loss: assert property (@(posedge clk) disable iff (!resetn)
        (superframe_period_tick && link_sync && !lock_sync && !write_take
        && near_error_count != count_max) |=> near_error_count == $past(near_error_count) + 8'h01)
        else $error("lock loss not counted");

    sequence s_far_count;
        rx_superframe_end && in_sync && !rx_far_error_bit && !write_take
        && far_error_count != count_max;
    endsequence

    sequence s_near_count;
        rx_superframe_end && in_sync && !rx_crc_match && !write_take
        && near_error_count != count_max;
    endsequence

    a_far_count: assert property (@(posedge clk) disable iff (!resetn)
        s_far_count |=> far_error_count == $past(far_error_count) + 8'h01)
        else $error("far error not counted");

    a_far_idle: assert property (@(posedge clk) disable iff (!resetn)
        (rx_superframe_end && rx_far_error_bit && !write_take) |=> $stable(far_error_count))
        else $error("far count moved without error");

    a_near_count: assert property (@(posedge clk) disable iff (!resetn)
        s_near_count |=> near_error_count == $past(near_error_count) + 8'h01)
        else $error("crc error not counted");

    a_far_slot: assert property (@(posedge clk) disable iff (!resetn)
        (tx_frame_end && tx_frame_number == frame_far_tx) |=> tx_far_error_valid)
        else $error("far bit slot missed");

    a_far_steady: assert property (@(posedge clk) disable iff (!resetn)
        !(tx_frame_end && tx_frame_number == frame_far_tx) |=> $stable(tx_far_error_bit))
        else $error("far bit moved outside slot");

    a_nt_window: assert property (@(posedge clk) disable iff (!resetn)
        (!mode_sync && (tx_frame_number < frame_nt_inv_first
        || tx_frame_number > frame_nt_inv_last)) |=> tx_crc_out == $past(tx_crc_bit))
        else $error("crc inverted outside window");

endmodule : error_monitor

// ===== core/error_monitor_pkg.sv
// Constants for the superframe error monitor and its register map
package error_monitor_pkg;

    // ==========================================================
    // Register word addresses (byte address = 4 * index) and bus address width
    localparam logic [2:0] reg_far_count = 3'h0;
    localparam logic [2:0] reg_near_count = 3'h1;
    localparam logic [2:0] reg_control = 3'h2;
    localparam logic [2:0] reg_status = 3'h3;
    localparam int addr_width = 5;

    // ==========================================================
    // Control register bit positions
    localparam int ctl_far_source = 0;
    localparam int ctl_far_input = 1;
    localparam int ctl_wrap = 2;
    localparam int ctl_crc_invert = 3;
    localparam int ctl_single = 4;
    localparam int ctl_width = 5;

    // Status register bit positions
    localparam int st_received_far = 0;
    localparam int st_near = 1;
    localparam int st_lock = 2;
    localparam int st_link = 3;
    localparam int st_tx_far = 4;
    localparam int st_invert_active = 5;

    // ==========================================================
    // Reset values and counter maximum
    localparam logic [7:0] count_reset = 8'h00;
    localparam logic [7:0] count_max = 8'hFF;
    localparam logic [ctl_width-1:0] control_reset = 5'h02;

    // ==========================================================
    // Basic frame numbers within a superframe
    localparam logic [3:0] frame_first = 4'h1;
    localparam logic [3:0] frame_far_tx = 4'h2;
    localparam logic [3:0] frame_nt_inv_first = 4'h4;
    localparam logic [3:0] frame_nt_inv_last = 4'h7;
    localparam logic [3:0] frame_last = 4'h8;

endpackage : error_monitor_pkg

// ===== verification/test_block_error_monitor_crc_corrupt.sv
// Self-checking bench for the superframe error monitor
`timescale 1ns/1ps
module test_block_error_monitor_crc_corrupt
    import error_monitor_pkg::*;
;
    localparam logic [4:0] a_far = {reg_far_count, 2'b00};
    localparam logic [4:0] a_near = {reg_near_count, 2'b00};
    localparam logic [4:0] a_ctl = {reg_control, 2'b00};
    localparam logic [4:0] a_st = {reg_status, 2'b00};
    localparam logic [4:0] a_bad = 5'h10;
    localparam logic [31:0] f32 = 32'hFFFFFFFF;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0, write = 1'b0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata, q;
    logic waitrequest;
    logic rx_superframe_end = 1'b0, rx_far_error_bit = 1'b1, rx_crc_match = 1'b1;
    logic superframe_period_tick = 1'b0, lock = 1'b0, link = 1'b0, mode = 1'b0;
    logic tx_frame_end, tx_superframe_end, tx_crc_bit, crc_prev;
    logic [3:0] tx_frame_number, fn_prev;
    logic tx_far_error_bit, tx_far_error_valid, tx_crc_out;
    int miscompares = 0;
    int n_compared = 0;

    always #10 clk = ~clk;
    always @(posedge clk) begin
        crc_prev <= tx_crc_bit;
        fn_prev <= tx_frame_number;
    end

    error_monitor uut (.clk(clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .rx_superframe_end(rx_superframe_end), .rx_far_error_bit(rx_far_error_bit),
        .rx_crc_match(rx_crc_match), .superframe_period_tick(superframe_period_tick),
        .superframe_lock(lock), .link_established(link), .line_end_mode(mode),
        .tx_frame_end(tx_frame_end), .tx_frame_number(tx_frame_number),
        .tx_superframe_end(tx_superframe_end), .tx_crc_bit(tx_crc_bit),
        .tx_far_error_bit(tx_far_error_bit), .tx_far_error_valid(tx_far_error_valid),
        .tx_crc_out(tx_crc_out));

    tx_frame_source far_end (.clk(clk), .resetn(resetn), .frame_end(tx_frame_end),
        .frame_number(tx_frame_number), .superframe_end(tx_superframe_end),
        .crc_bit(tx_crc_bit));

    // ==========================================================
    // Checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // ==========================================================
    // Bus cycles; ev raises a receive event at the completing edge
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d,
                          input logic ev);
        int n;
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= {24'h000000, d};
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
            rx_superframe_end <= ev;
        end
        if (n == 20) begin
            miscompares++;
            give_verdict();
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        rx_superframe_end <= 1'b0;
    endtask : access

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        access(1'b1, a, d, 1'b0);
    endtask : wr

    task automatic rc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        access(1'b0, a, 8'h00, 1'b0);
        check(q & m, e);
    endtask : rc

    // ==========================================================
    // Line events and transmit observation
    task automatic pins(input logic lk, input logic ln, input logic md);
        @(posedge clk);
        lock <= lk;
        link <= ln;
        mode <= md;
        repeat (4) @(posedge clk);
    endtask : pins

    task automatic pulse(input logic e, input logic f, input logic m, input logic t);
        @(posedge clk);
        rx_superframe_end <= e;
        rx_far_error_bit <= f;
        rx_crc_match <= m;
        superframe_period_tick <= t;
        @(posedge clk);
        rx_superframe_end <= 1'b0;
        superframe_period_tick <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse

    task automatic txbit(input logic e);
        int n, k;
        k = 0;
        for (n = 0; n < 300 && k < 2; n++) begin
            @(negedge clk);
            if (tx_far_error_valid === 1'b1) k++;
        end
        if (k < 2) begin
            miscompares++;
            give_verdict();
        end
        check(tx_frame_number, 32'h3);
        check(tx_far_error_bit, e);
    endtask : txbit

    // Per-frame masks of inverted and clean crc cycles over one superframe
    task automatic crc_sf(input logic [17:0] e);
        logic [8:0] inv, pl;
        int n;
        inv = 9'h000;
        pl = 9'h000;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(fn_prev === 4'h8 && tx_frame_number === 4'h1) && n < 200);
        if (n >= 200) begin
            miscompares++;
            give_verdict();
        end
        repeat (64) begin
            @(negedge clk);
            if ((tx_crc_out ^ crc_prev) === 1'b1) inv[fn_prev] = 1'b1;
            else pl[fn_prev] = 1'b1;
        end
        check({inv, pl}, e);
    endtask : crc_sf

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rc(a_far, f32, 32'h0);
        rc(a_ctl, f32, 32'h02);
        rc(a_st, 32'h2E, 32'h0);
        wr(a_bad, 8'hFF);
        rc(a_bad, f32, 32'h0);
        crc_sf({9'h000, 9'h1FE});
        pins(1'b1, 1'b1, 1'b0);
        rc(a_st, 32'h0C, 32'h0C);
        pulse(1'b1, 1'b0, 1'b0, 1'b0);
        rc(a_far, f32, 32'h1);
        rc(a_near, f32, 32'h1);
        rc(a_st, 32'h03, 32'h0);
        pulse(1'b1, 1'b1, 1'b1, 1'b0);
        rc(a_st, 32'h03, 32'h3);
        rc(a_far, f32, 32'h1);
        txbit(1'b1);
        rc(a_st, 32'h10, 32'h10);
        wr(a_ctl, 8'h00);
        txbit(1'b0);
        pulse(1'b1, 1'b1, 1'b0, 1'b0);
        wr(a_ctl, 8'h03);
        txbit(1'b1);
        wr(a_ctl, 8'h01);
        txbit(1'b0);
        wr(a_ctl, 8'h02);
        txbit(1'b0);
        pulse(1'b1, 1'b1, 1'b1, 1'b0);
        rc(a_st, 32'h02, 32'h2);
        pins(1'b0, 1'b1, 1'b0);
        rc(a_st, 32'h02, 32'h0);
        pulse(1'b1, 1'b0, 1'b0, 1'b0);
        rc(a_st, 32'h01, 32'h1);
        rc(a_far, f32, 32'h1);
        pulse(1'b0, 1'b0, 1'b0, 1'b1);
        rc(a_near, f32, 32'h3);
        pins(1'b1, 1'b1, 1'b0);
        wr(a_far, 8'hFF);
        wr(a_near, 8'hFF);
        pulse(1'b1, 1'b0, 1'b0, 1'b0);
        rc(a_far, f32, 32'hFF);
        rc(a_near, f32, 32'hFF);
        wr(a_ctl, 8'h06);
        pulse(1'b1, 1'b0, 1'b0, 1'b0);
        rc(a_far, f32, 32'h0);
        rc(a_near, f32, 32'h0);
        access(1'b1, a_far, 8'h55, 1'b1);
        rc(a_far, f32, 32'h55);
        rc(a_near, f32, 32'h1);
        wr(a_far, 8'h00);
        wr(a_near, 8'h00);
        rc(a_far, f32, 32'h0);
        rc(a_near, f32, 32'h0);
        byteenable <= 4'hE;
        wr(a_far, 8'h77);
        byteenable <= 4'hF;
        rc(a_far, f32, 32'h0);
        wr(a_ctl, 8'h0A);
        crc_sf({9'h0F0, 9'h10E});
        crc_sf({9'h0F0, 9'h10E});
        rc(a_ctl, f32, 32'h0A);
        wr(a_ctl, 8'h02);
        pins(1'b1, 1'b1, 1'b1);
        wr(a_ctl, 8'h0A);
        crc_sf({9'h1FE, 9'h000});
        wr(a_ctl, 8'h1A);
        crc_sf({9'h000, 9'h1FE});
        rc(a_ctl, f32, 32'h12);
        give_verdict();
    end
endmodule : test_block_error_monitor_crc_corrupt

// ===== verification/tx_frame_source.sv
// Far-end transmit framer model: basic frame timing and raw crc bits
`timescale 1ns/1ps
module tx_frame_source #(
    parameter int frame_cycles = 8
) (
    input wire logic clk,
    input wire logic resetn,
    output logic frame_end,
    output logic [3:0] frame_number,
    output logic superframe_end,
    output logic crc_bit
);
    // ==========================================================
    // Basic frames 1 to 8 of a superframe
    int cyc;
    assign frame_end = (cyc == frame_cycles - 1);
    assign superframe_end = frame_end && (frame_number == 4'h8);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cyc <= 0;
            frame_number <= 4'h1;
            crc_bit <= 1'b0;
        end else begin
            // Raw crc changes often so inversion shows in every frame
            crc_bit <= ~crc_bit ^ cyc[1];
            cyc <= frame_end ? 0 : cyc + 1;
            if (frame_end) begin
                frame_number <= (frame_number == 4'h8) ? 4'h1 : frame_number + 4'h1;
            end
        end
    end
endmodule : tx_frame_source
